// ===== rtl/cmsv_defs.svh
// Constants of the message-object status view
//
// What this block does
// R1: Word one of transmit-pending shows objects 1 to 16 in bits 15:0.
// R2: Word two of transmit-pending shows objects 17 to 32 in bits 15:0.
// R3: A transmit-pending bit is 1 while a send is asked for and not done.
// R4: Transmit-pending is written via the message interface set, set on remote frame receipt and cleared on a good send.
// R5: Word one of fresh-payload shows objects 1 to 16 in bits 15:0.
// R6: Word two of fresh-payload shows objects 17 to 32 in bits 15:0.
// R7: Fresh-payload is written via the message interface set and updated on data frame receipt or a good send.
// R8: A fresh-payload bit is 1 once new data was written and 0 if none since the last clear.
// R9: The irq-flag word shows objects 1 to 16 in bits 15:0.
// R10: The irq flag is written via the message interface set and set after a good receive or send.
// R11: Every irq flag change also shows in the interrupt identifier outputs; they give only the lowest pending object and whether any is pending.
// R12: An irq-flag bit is 1 when its object is an interrupt source.
// R13: After reset every flag in these words reads zero.
// R14: All status words are read-only and reflect the handler's flags.
// R15: Bits 31:16 read zero and writes to the status words do nothing.
`ifndef CMSV_DEFS_SVH
`define CMSV_DEFS_SVH

`define CMSV_ADDR_TXREQ_LO 32'h4005_0100
`define CMSV_ADDR_TXREQ_HI 32'h4005_0104
`define CMSV_ADDR_FRESH_LO 32'h4005_0120
`define CMSV_ADDR_FRESH_HI 32'h4005_0124
`define CMSV_ADDR_IRQ_LO 32'h4005_0140

`define CMSV_OBJ_COUNT 32
`define CMSV_HALF_W 16
`define CMSV_OBJ_NUM_W 6
`define CMSV_FLAGS_RST 32'h0000_0000
`define CMSV_UPPER_ZERO 16'h0000
`define CMSV_WORD_ZERO 32'h0000_0000
`define CMSV_NO_OBJ 6'h00
`define CMSV_FIRST_OBJ 6'h01
`define CMSV_LAST_OBJ 6'h20

`endif

// ===== rtl/cmsv_pkg.sv
// Types of the message-object status view
package cmsv_pkg;

  typedef enum logic [1:0] {
    CMSV_EVT_NONE = 2'h0,
    CMSV_EVT_REMOTE_RX = 2'h1,
    CMSV_EVT_DATA_RX = 2'h3,
    CMSV_EVT_TX_DONE = 2'h2
  } cmsv_evt_t;

  typedef enum logic [1:0] {
    CMSV_ST_IDLE = 2'h0,
    CMSV_ST_ANSWER = 2'h1
  } cmsv_apb_st_t;

endpackage : cmsv_pkg

// ===== rtl/cmsv_flag_bank.sv
// Bank of per-object flags where a set beats a clear
`timescale 1ns/100ps
`default_nettype none

module cmsv_flag_bank #(
  parameter int N = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [N-1:0] set_vec,
  input wire logic [N-1:0] clr_vec,
  output logic [N-1:0] flags_r
);

  logic [N-1:0] flags_nxt;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      // Set wins over a clear in the same cycle
      assign flags_nxt[i] = set_vec[i] | (flags_r[i] & ~clr_vec[i]);
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

endmodule : cmsv_flag_bank

`default_nettype wire

// ===== rtl/cmsv_status_view.sv
// Message-object status view: flag keeping and APB read-only window
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "cmsv_defs.svh"

module cmsv_status_view (
  input wire logic CLOCK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Message interface set writes
  input wire logic MIF_WRITE,
  input wire logic [5:0] MIF_OBJ,
  input wire logic MIF_UPD_TX,
  input wire logic MIF_UPD_FRESH,
  input wire logic MIF_UPD_IRQ,
  input wire logic MIF_TX_VAL,
  input wire logic MIF_FRESH_VAL,
  input wire logic MIF_IRQ_VAL,
  // Message handler events
  input wire logic MH_EVT_VALID,
  input wire logic [5:0] MH_EVT_OBJ,
  input wire logic [1:0] MH_EVT_KIND,
  // Flag state seen by the rest of the controller
  output logic [31:0] TX_PENDING_OBJS,
  output logic IRQ_PENDING_ANY,
  output logic [5:0] IRQ_IDENT
);

  localparam int N = `CMSV_OBJ_COUNT;
  localparam int H = `CMSV_HALF_W;

  ////////////////////////////////////////////////////////////////////////////

  // Object number to one-hot; zero or out of range selects nothing
  // The index wraps for object zero, so the range test gates the shift
  function automatic logic [N-1:0] obj_onehot(
    input logic [5:0] num
  );
    logic [5:0] idx;
    logic [N-1:0] hot;
    idx = num - `CMSV_FIRST_OBJ;
    hot = '0;
    if (num != `CMSV_NO_OBJ && num <= `CMSV_LAST_OBJ) begin
      hot = {{(N-1){1'b0}}, 1'b1} << idx;
    end
    return hot;
  endfunction : obj_onehot

  ////////////////////////////////////////////////////////////////////////////
  // Event decode

  cmsv_pkg::cmsv_evt_t evt_kind;
  logic [N-1:0] mif_sel;
  logic [N-1:0] mh_sel;
  logic mh_remote;
  logic mh_data;
  logic mh_txdone;
  logic mh_any;

  always_comb begin
    evt_kind = cmsv_pkg::cmsv_evt_t'(MH_EVT_KIND);
    mif_sel = MIF_WRITE ? obj_onehot(MIF_OBJ) : '0;
    mh_sel = MH_EVT_VALID ? obj_onehot(MH_EVT_OBJ) : '0;
    mh_remote = 1'b0;
    mh_data = 1'b0;
    mh_txdone = 1'b0;
    case (evt_kind)
      cmsv_pkg::CMSV_EVT_REMOTE_RX: begin
        mh_remote = 1'b1;
      end
      cmsv_pkg::CMSV_EVT_DATA_RX: begin
        mh_data = 1'b1;
      end
      cmsv_pkg::CMSV_EVT_TX_DONE: begin
        mh_txdone = 1'b1;
      end
      default: begin
        mh_remote = 1'b0;
      end
    endcase
    mh_any = mh_remote | mh_data | mh_txdone;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Set and clear vectors of the three flag sets

  logic [N-1:0] tx_set;
  logic [N-1:0] tx_clr;
  logic [N-1:0] fresh_set;
  logic [N-1:0] fresh_clr;
  logic [N-1:0] irq_set;
  logic [N-1:0] irq_clr;
  logic [N-1:0] mif_tx;
  logic [N-1:0] mif_fresh;
  logic [N-1:0] mif_irq;

  always_comb begin
    // Only the flags named by the write move; the others hold
    mif_tx = MIF_UPD_TX ? mif_sel : '0;
    mif_fresh = MIF_UPD_FRESH ? mif_sel : '0;
    mif_irq = MIF_UPD_IRQ ? mif_sel : '0;
    // CPU writes either value; remote frame sets, good send clears
    tx_set = (MIF_TX_VAL ? mif_tx : '0)
      | (mh_remote ? mh_sel : '0); // [R4]
    tx_clr = (MIF_TX_VAL ? '0 : mif_tx)
      | (mh_txdone ? mh_sel : '0); // [R4] [R3]
    // Data frame stores fresh data; a finished send consumes it
    fresh_set = (MIF_FRESH_VAL ? mif_fresh : '0)
      | (mh_data ? mh_sel : '0); // [R7] [R8]
    fresh_clr = (MIF_FRESH_VAL ? '0 : mif_fresh)
      | (mh_txdone ? mh_sel : '0); // [R7]
    // Any good receive or send raises the object's irq flag
    irq_set = (MIF_IRQ_VAL ? mif_irq : '0)
      | (mh_any ? mh_sel : '0); // [R10]
    irq_clr = MIF_IRQ_VAL ? '0 : mif_irq; // [R10]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag storage
  // Flag i belongs to object i + 1
  // A set beats a clear from either source in the same cycle

  logic [N-1:0] tx_flags;
  logic [N-1:0] fresh_flags;
  logic [N-1:0] irq_flags;

  cmsv_flag_bank #(
    .N(N)
  ) u_tx_bank (
    .clk(CLOCK),
    .rst(RST),
    .set_vec(tx_set),
    .clr_vec(tx_clr),
    .flags_r(tx_flags)
  ); // [R13]

  cmsv_flag_bank #(
    .N(N)
  ) u_fresh_bank (
    .clk(CLOCK),
    .rst(RST),
    .set_vec(fresh_set),
    .clr_vec(fresh_clr),
    .flags_r(fresh_flags)
  ); // [R13]

  cmsv_flag_bank #(
    .N(N)
  ) u_irq_bank (
    .clk(CLOCK),
    .rst(RST),
    .set_vec(irq_set),
    .clr_vec(irq_clr),
    .flags_r(irq_flags)
  ); // [R13]

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt identifier: lowest numbered pending object

  logic irq_any_r;
  logic irq_any_nxt;
  logic [5:0] irq_ident_r;
  logic [5:0] irq_ident_nxt;

  // Covers all 32 objects, though only 1 to 16 are readable here
  always_comb begin
    irq_any_nxt = |irq_flags; // [R11] [R12]
    irq_ident_nxt = `CMSV_NO_OBJ;
    for (int i = N - 1; i >= 0; i--) begin
      if (irq_flags[i]) begin
        irq_ident_nxt = 6'(i + 1); // [R11]
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      irq_any_r <= 1'b0;
      irq_ident_r <= `CMSV_NO_OBJ;
    end else begin
      irq_any_r <= irq_any_nxt;
      irq_ident_r <= irq_ident_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit-pending mirror for the rest of the controller

  logic [N-1:0] tx_out_r;
  logic [N-1:0] tx_out_nxt;

  always_comb begin
    // Lags the read words by one cycle
    tx_out_nxt = tx_flags; // [R3]
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      tx_out_r <= `CMSV_FLAGS_RST;
    end else begin
      tx_out_r <= tx_out_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status words as software sees them; upper half always zero

  logic [31:0] tx_lo_word;
  logic [31:0] tx_hi_word;
  logic [31:0] fresh_lo_word;
  logic [31:0] fresh_hi_word;
  logic [31:0] irq_lo_word;

  always_comb begin
    tx_lo_word = {`CMSV_UPPER_ZERO, tx_flags[H-1:0]}; // [R1] [R15]
    tx_hi_word = {`CMSV_UPPER_ZERO, tx_flags[N-1:H]}; // [R2] [R15]
    fresh_lo_word = {`CMSV_UPPER_ZERO, fresh_flags[H-1:0]}; // [R5] [R15]
    fresh_hi_word = {`CMSV_UPPER_ZERO, fresh_flags[N-1:H]}; // [R6] [R15]
    irq_lo_word = {`CMSV_UPPER_ZERO, irq_flags[H-1:0]}; // [R9] [R15]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read word selection

  logic [31:0] rd_word;
  logic rd_hit;

  // Full 32-bit compare, so aliases of the words are not decoded
  // Unmapped addresses read zero and raise the error response
  always_comb begin
    rd_word = `CMSV_WORD_ZERO;
    rd_hit = 1'b1;
    if (PADDR == `CMSV_ADDR_TXREQ_LO) begin
      rd_word = tx_lo_word; // [R1]
    end else if (PADDR == `CMSV_ADDR_TXREQ_HI) begin
      rd_word = tx_hi_word; // [R2]
    end else if (PADDR == `CMSV_ADDR_FRESH_LO) begin
      rd_word = fresh_lo_word; // [R5]
    end else if (PADDR == `CMSV_ADDR_FRESH_HI) begin
      rd_word = fresh_hi_word; // [R6]
    end else if (PADDR == `CMSV_ADDR_IRQ_LO) begin
      rd_word = irq_lo_word; // [R9]
    end else begin
      rd_hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access phase after each setup

  cmsv_pkg::cmsv_apb_st_t st_r;
  cmsv_pkg::cmsv_apb_st_t st_nxt;
  logic setup;
  logic take;

  // A setup that arrives while the answer is out is not taken
  always_comb begin
    setup = PSEL & ~PENABLE;
    take = 1'b0;
    st_nxt = st_r;
    case (st_r)
      cmsv_pkg::CMSV_ST_IDLE: begin
        if (setup) begin
          st_nxt = cmsv_pkg::CMSV_ST_ANSWER;
          take = 1'b1;
        end
      end
      cmsv_pkg::CMSV_ST_ANSWER: begin
        st_nxt = cmsv_pkg::CMSV_ST_IDLE;
      end
      default: begin
        st_nxt = cmsv_pkg::CMSV_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st_r <= cmsv_pkg::CMSV_ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB response: ready, error and read data stand for one cycle only

  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;

  always_comb begin
    // Zero wait states: ready follows the setup edge
    pready_nxt = take;
    pslverr_nxt = take & ~rd_hit;
    prdata_nxt = `CMSV_WORD_ZERO;
    // Writes store nothing; reads take the current flags
    if (take && !PWRITE && rd_hit) begin
      prdata_nxt = rd_word; // [R14] [R15]
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      prdata_r <= `CMSV_WORD_ZERO;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Every output is a flop; the flag mirror lags the read words
  // by one cycle, the identifier by one cycle after the flag

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign TX_PENDING_OBJS = tx_out_r;
  assign IRQ_PENDING_ANY = irq_any_r;
  assign IRQ_IDENT = irq_ident_r;

  // Write data is deliberately unused: every word here is read-only
  logic unused_wdata;
  assign unused_wdata = ^PWDATA;

endmodule : cmsv_status_view

`default_nettype wire

// ===== verif/cmsv_status_view_sva.sv
// Checker of the message-object status view ports
`timescale 1ns/100ps
`default_nettype none
`include "cmsv_defs.svh"
module cmsv_status_view_sva (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic MIF_WRITE,
  input wire logic MH_EVT_VALID,
  input wire logic [5:0] MH_EVT_OBJ,
  input wire logic [1:0] MH_EVT_KIND,
  input wire logic [31:0] TX_PENDING_OBJS,
  input wire logic IRQ_PENDING_ANY,
  input wire logic [5:0] IRQ_IDENT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  logic setup;
  logic ev_ok;
  assign setup = PSEL && !PENABLE && !PREADY;
  assign ev_ok = MH_EVT_VALID && !MIF_WRITE && MH_EVT_OBJ inside {[1:32]};
  ////////////////////////////////////////
  property p_answer;
    setup |=> PREADY;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_upper;
    PREADY |-> PRDATA[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits");
  property p_txlo;
    PREADY && !PWRITE && PADDR == `CMSV_ADDR_TXREQ_LO |-> PRDATA[15:0] ==
      TX_PENDING_OBJS[15:0];
  endproperty
  a_txlo: assert property (p_txlo) else $error("tx low word");
  property p_txhi;
    PREADY && !PWRITE && PADDR == `CMSV_ADDR_TXREQ_HI |-> PRDATA[15:0] ==
      TX_PENDING_OBJS[31:16];
  endproperty
  a_txhi: assert property (p_txhi) else $error("tx high word");
  property p_ident;
    PREADY && PADDR == `CMSV_ADDR_IRQ_LO && PRDATA[0] |-> IRQ_IDENT == 6'h01;
  endproperty
  a_ident: assert property (p_ident) else $error("irq ident");
  property p_any;
    IRQ_PENDING_ANY == (IRQ_IDENT != 6'h00);
  endproperty
  a_any: assert property (p_any) else $error("irq any");
  property p_txset;
    ev_ok && MH_EVT_KIND == cmsv_pkg::CMSV_EVT_REMOTE_RX |-> ##2
      TX_PENDING_OBJS[$past(MH_EVT_OBJ, 2) - 6'h01];
  endproperty
  a_txset: assert property (p_txset) else $error("tx not set");
  property p_txclr;
    ev_ok && MH_EVT_KIND == cmsv_pkg::CMSV_EVT_TX_DONE |-> ##2
      !TX_PENDING_OBJS[$past(MH_EVT_OBJ, 2) - 6'h01];
  endproperty
  a_txclr: assert property (p_txclr) else $error("tx not clear");
endmodule : cmsv_status_view_sva
bind cmsv_status_view cmsv_status_view_sva cmsv_status_view_sva_i (.CLOCK,
  .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .MIF_WRITE,
  .MH_EVT_VALID, .MH_EVT_OBJ, .MH_EVT_KIND, .TX_PENDING_OBJS,
  .IRQ_PENDING_ANY, .IRQ_IDENT);
`default_nettype wire

// ===== verif/cmsv_status_view_tb_top.sv
// Testbench of the message-object status view
`timescale 1ns/100ps
`default_nettype none
`include "cmsv_defs.svh"
module cmsv_status_view_tb_top;
  logic CLOCK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [31:0] PADDR, PWDATA, PRDATA, TX_PENDING_OBJS;
  logic MIF_WRITE, MIF_UPD_TX, MIF_UPD_FRESH, MIF_UPD_IRQ;
  logic MIF_TX_VAL, MIF_FRESH_VAL, MIF_IRQ_VAL, MH_EVT_VALID;
  logic IRQ_PENDING_ANY;
  logic [5:0] MIF_OBJ, MH_EVT_OBJ, IRQ_IDENT;
  logic [1:0] MH_EVT_KIND;
  int num_errors = 0;
  int cmp_count = 0;
  cmsv_status_view cmsv_status_view_i (.CLOCK, .RST, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .MIF_WRITE,
    .MIF_OBJ, .MIF_UPD_TX, .MIF_UPD_FRESH, .MIF_UPD_IRQ, .MIF_TX_VAL,
    .MIF_FRESH_VAL, .MIF_IRQ_VAL, .MH_EVT_VALID, .MH_EVT_OBJ,
    .MH_EVT_KIND, .TX_PENDING_OBJS, .IRQ_PENDING_ANY, .IRQ_IDENT);
  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end
  ////////////////////////////////////////
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  task acc(input logic w, input logic [31:0] a, d, e, input logic r);
    int n;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    chk({31'h0, PREADY}, 32'h1);
    chk(PRDATA, e);
    chk({31'h0, PSLVERR}, {31'h0, r});
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : acc
  task rd(input logic [31:0] a, e);
    acc(1'b0, a, '0, e, 1'b0);
  endtask : rd
  // Handler event and interface write in the same cycle
  task ev(input logic [5:0] o, input logic [1:0] k, input logic m,
    input logic [2:0] u, v);
    @(posedge CLOCK);
    MH_EVT_VALID <= 1'b1;
    MH_EVT_OBJ <= o;
    MH_EVT_KIND <= k;
    MIF_WRITE <= m;
    MIF_OBJ <= o;
    {MIF_UPD_TX, MIF_UPD_FRESH, MIF_UPD_IRQ} <= u;
    {MIF_TX_VAL, MIF_FRESH_VAL, MIF_IRQ_VAL} <= v;
    @(posedge CLOCK);
    MH_EVT_VALID <= 1'b0;
    MIF_WRITE <= 1'b0;
  endtask : ev
  ////////////////////////////////////////
  task t_reset;
    rd(`CMSV_ADDR_TXREQ_LO, '0);
    rd(`CMSV_ADDR_TXREQ_HI, '0);
    rd(`CMSV_ADDR_FRESH_LO, '0);
    rd(`CMSV_ADDR_FRESH_HI, '0);
    rd(`CMSV_ADDR_IRQ_LO, '0);
    acc(1'b0, 32'h4005_0108, '0, '0, 1'b1);
    $display("t_reset done");
  endtask : t_reset
  task t_rx;
    ev(6'd1, cmsv_pkg::CMSV_EVT_REMOTE_RX, 1'b0, '0, '0);
    ev(6'd32, cmsv_pkg::CMSV_EVT_REMOTE_RX, 1'b0, '0, '0);
    ev(6'd16, cmsv_pkg::CMSV_EVT_DATA_RX, 1'b0, '0, '0);
    ev(6'd17, cmsv_pkg::CMSV_EVT_DATA_RX, 1'b0, '0, '0);
    rd(`CMSV_ADDR_TXREQ_LO, 32'h1);
    rd(`CMSV_ADDR_TXREQ_HI, 32'h8000);
    rd(`CMSV_ADDR_FRESH_LO, 32'h8000);
    rd(`CMSV_ADDR_FRESH_HI, 32'h1);
    rd(`CMSV_ADDR_IRQ_LO, 32'h8001);
    chk({26'h0, IRQ_IDENT}, 32'h1);
    $display("t_rx done");
  endtask : t_rx
  task t_tx;
    ev(6'd1, cmsv_pkg::CMSV_EVT_TX_DONE, 1'b0, '0, '0);
    ev(6'd16, cmsv_pkg::CMSV_EVT_TX_DONE, 1'b0, '0, '0);
    rd(`CMSV_ADDR_TXREQ_LO, '0);
    rd(`CMSV_ADDR_FRESH_LO, '0);
    rd(`CMSV_ADDR_IRQ_LO, 32'h8001);
    $display("t_tx done");
  endtask : t_tx
  task t_mif;
    ev(6'd1, cmsv_pkg::CMSV_EVT_NONE, 1'b1, 3'b001, 3'b000);
    ev(6'd5, cmsv_pkg::CMSV_EVT_NONE, 1'b1, 3'b100, 3'b100);
    ev(6'd16, cmsv_pkg::CMSV_EVT_REMOTE_RX, 1'b1, 3'b001, 3'b000);
    ev(6'd17, cmsv_pkg::CMSV_EVT_NONE, 1'b1, 3'b010, 3'b000);
    ev(6'd0, cmsv_pkg::CMSV_EVT_REMOTE_RX, 1'b1, 3'b111, 3'b111);
    rd(`CMSV_ADDR_TXREQ_LO, 32'h8010);
    rd(`CMSV_ADDR_IRQ_LO, 32'h8000);
    rd(`CMSV_ADDR_FRESH_HI, '0);
    chk({26'h0, IRQ_IDENT}, 32'd16);
    chk({31'h0, IRQ_PENDING_ANY}, 32'h1);
    chk(TX_PENDING_OBJS, 32'h8000_8010);
    $display("t_mif done");
  endtask : t_mif
  task t_write;
    acc(1'b1, `CMSV_ADDR_TXREQ_LO, '1, '0, 1'b0);
    acc(1'b1, `CMSV_ADDR_FRESH_HI, '1, '0, 1'b0);
    rd(`CMSV_ADDR_TXREQ_LO, 32'h8010);
    rd(`CMSV_ADDR_FRESH_HI, '0);
    $display("t_write done");
  endtask : t_write
  ////////////////////////////////////////
  initial begin
    RST = 1'b1;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {MIF_WRITE, MIF_OBJ, MIF_UPD_TX, MIF_UPD_FRESH, MIF_UPD_IRQ} = '0;
    {MIF_TX_VAL, MIF_FRESH_VAL, MIF_IRQ_VAL} = '0;
    {MH_EVT_VALID, MH_EVT_OBJ, MH_EVT_KIND} = '0;
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    t_reset;
    t_rx;
    t_tx;
    t_mif;
    t_write;
    end_of_test;
  end
  initial begin
    #20000;
    num_errors++;
    end_of_test;
  end
endmodule : cmsv_status_view_tb_top
`default_nettype wire
